// *** rttc_pkg.sv ***
// Constants, register map and field layouts of the real-time counter block.
// Assumes a 32-bit Avalon-MM slave bus with byte addresses.
package rttc_pkg;

    // ========================================================================
    // Register byte offsets, one aligned word each
    localparam logic [4:0] OFS_FLAG      = 5'h00;
    localparam logic [4:0] OFS_MODE      = 5'h04;
    localparam logic [4:0] OFS_MATCH     = 5'h08;
    localparam logic [4:0] OFS_SUBSEC    = 5'h0C;
    localparam logic [4:0] OFS_TWOSEC    = 5'h10;
    localparam logic [4:0] OFS_DAY       = 5'h14;
    localparam logic [4:0] OFS_IRQ_STAT  = 5'h18;
    localparam logic [4:0] OFS_IRQ_MASK  = 5'h1C;

    // ========================================================================
    // Field positions
    localparam int FLG_ALARM_BIT   = 7;
    localparam int FLG_PERIOD_BIT  = 6;
    localparam int FLG_ACLR_BIT    = 5;
    localparam int FLG_PCLR_BIT    = 4;
    localparam int MODE_LDDAY_BIT  = 7;
    localparam int MODE_LDSUB_BIT  = 6;
    localparam int MODE_AEN_BIT    = 5;
    localparam int MODE_PEN_BIT    = 4;
    localparam int MODE_IGN_BIT    = 3;
    localparam int DAY_WIDTH       = 14;
    localparam int IRQ_PERIOD_BIT  = 0;
    localparam int IRQ_ALARM_BIT   = 1;

    // ========================================================================
    // Reset values and counts
    localparam logic [2:0]  INTERVAL_RST   = 3'h2;
    localparam logic [31:0] MATCH_RST      = 32'h0000_0000;
    localparam logic [15:0] TWOSEC_PER_DAY = 16'hA8C0;  // 43200
    localparam int          LS_CLK_HZ      = 32768;
    localparam int          SYS_CLK_HZ     = 250_000_000;
    localparam int          SWITCH_WAIT_US = 16;        // Software-side wait only
    // Base tick is 1/8 s: 4096 low-speed cycles
    localparam logic [11:0] EIGHTH_MASK    = 12'hFFF;

    // ========================================================================
    // Mode control fields
    typedef struct packed {
        logic       ignore_lsb;
        logic       alarm_en;
        logic       period_en;
        logic [2:0] interval;
    } rttc_mode_t;

endpackage : rttc_pkg

// *** rttc_top.sv ***
// Real-time counter with periodic and alarm modes behind an Avalon-MM slave.
// Assumes i_ls_tick is a one-cycle pulse per 32768 Hz cycle, synchronous to
// i_clk, and that i_sys_rst is the system reset that must not disturb time.
//
// Operation
// - Three-bit interval code, 1/8 to 16 s
// - Periodic mode sets flag each interval
// - Periodic clear bit reads 1 when off
// - Alarm clear bit reads 1 when off
// - Flags at bits 7 and 6, read-only
// - Alarm compares counters with match halves
// - Full match sets alarm flag, interrupt
// - Ignore-LSB drops match bit zero
// - Day load copies low 14 bits
// - Sub-day load copies both halves
// - Sub-second counter advances each tick
// - Day counter fourteen bits, upper zero
// - State survives system reset; ack_q, read data and waitrequest are reset by it
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module rttc_top (
    input  wire logic        i_clk,            // System clock, 250 MHz
    input  wire logic        i_sys_rst,        // Sync reset, active high
    input  wire logic        i_por,            // Power-on reset, active high
    input  wire logic        i_ls_tick,        // One pulse per 32768 Hz cycle
    input  wire logic [4:0]  i_avs_address,    // Byte address
    input  wire logic        i_avs_read,       // Read request
    input  wire logic        i_avs_write,      // Write request
    input  wire logic [31:0] i_avs_writedata,  // Write data
    input  wire logic [3:0]  i_avs_byteenable, // Byte enables
    output logic [31:0]      o_avs_readdata,   // Read data
    output logic             o_avs_waitrequest,// Wait request
    output logic             o_irq             // Level interrupt
);

    // ========================================================================
    // State
    rttc_pkg::rttc_mode_t mode_q;
    logic [31:0] match_q;
    logic [15:0] subsec_q;
    logic [15:0] twosec_q;
    logic [rttc_pkg::DAY_WIDTH-1:0] day_q;
    logic        alarm_flag_q;
    logic        period_flag_q;
    logic [1:0]  irq_stat_q;
    logic [1:0]  irq_mask_q;
    logic        ack_q;
    logic        alarm_hit_q;

    // ========================================================================
    // Bus decode
    logic        acc;
    logic        wr;
    logic        wr_flag;
    logic        wr_mode;
    logic        wr_match;
    logic        wr_stat;
    logic        wr_mask;
    logic        ld_day;
    logic        ld_sub;
    logic        clr_alarm;
    logic        clr_period;

    // A request is taken while no answer is pending
    assign acc        = (i_avs_read | i_avs_write) & ~ack_q;
    // A write lands only at the edge where waitrequest is seen low
    assign wr         = i_avs_write & ~o_avs_waitrequest;

    // Write strobe per register; the 8-bit registers need lane zero
    always_comb begin
        wr_flag  = 1'b0;
        wr_mode  = 1'b0;
        wr_match = 1'b0;
        wr_stat  = 1'b0;
        wr_mask  = 1'b0;
        if (wr) begin
            if (i_avs_address == rttc_pkg::OFS_FLAG) begin
                wr_flag = i_avs_byteenable[0];
            end else if (i_avs_address == rttc_pkg::OFS_MODE) begin
                wr_mode = i_avs_byteenable[0];
            end else if (i_avs_address == rttc_pkg::OFS_MATCH) begin
                wr_match = 1'b1;
            end else if (i_avs_address == rttc_pkg::OFS_IRQ_STAT) begin
                wr_stat = i_avs_byteenable[0];
            end else if (i_avs_address == rttc_pkg::OFS_IRQ_MASK) begin
                wr_mask = i_avs_byteenable[0];
            end
        end
    end

    // Load strobes and flag clears ride on the decoded writes
    assign ld_day     = wr_mode & i_avs_writedata[rttc_pkg::MODE_LDDAY_BIT];
    assign ld_sub     = wr_mode & i_avs_writedata[rttc_pkg::MODE_LDSUB_BIT];
    // Clear only acts while the matching mode is on
    assign clr_alarm  = wr_flag & i_avs_writedata[rttc_pkg::FLG_ACLR_BIT]
                        & mode_q.alarm_en;
    assign clr_period = wr_flag & i_avs_writedata[rttc_pkg::FLG_PCLR_BIT]
                        & mode_q.period_en;

    // ========================================================================
    // Event detection
    logic        period_evt;
    logic        match_lo;
    logic        match_hi;
    logic        alarm_match;
    logic        alarm_evt;

    // Interval n spans 4096 << n low-speed cycles; counter low bits all ones
    always_comb begin
        period_evt = 1'b0;
        if (i_ls_tick && mode_q.period_en) begin
            case (mode_q.interval)
                3'h0:    period_evt = (subsec_q[11:0] == rttc_pkg::EIGHTH_MASK);
                3'h1:    period_evt = (subsec_q[12:0] == 13'h1FFF);
                3'h2:    period_evt = (subsec_q[13:0] == 14'h3FFF);
                3'h3:    period_evt = (subsec_q[14:0] == 15'h7FFF);
                3'h4:    period_evt = (subsec_q == 16'hFFFF);
                3'h5:    period_evt = (subsec_q == 16'hFFFF) && twosec_q[0];
                3'h6:    period_evt = (subsec_q == 16'hFFFF) && (twosec_q[1:0] == 2'h3);
                default: period_evt = (subsec_q == 16'hFFFF) && (twosec_q[2:0] == 3'h7);
            endcase
        end
    end

    // Compare both halves, optionally without bit zero
    assign match_hi    = (twosec_q == match_q[31:16]);
    assign match_lo    = mode_q.ignore_lsb ? (subsec_q[15:1] == match_q[15:1])
                                           : (subsec_q == match_q[15:0]);
    assign alarm_match = mode_q.alarm_en & match_hi & match_lo;
    // One event on entering a match, not every cycle it holds
    assign alarm_evt   = alarm_match & ~alarm_hit_q;

    // ========================================================================
    // Counters: reset only by power-on, never by system reset

    // Sub-second counter, one step per low-speed tick
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            subsec_q <= 16'h0000;
        end else if (ld_sub) begin
            subsec_q <= match_q[15:0];
        end else if (i_ls_tick) begin
            subsec_q <= subsec_q + 16'h0001;
        end
    end

    // Two-second counter, stepped as the sub-second count wraps
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            twosec_q <= 16'h0000;
        end else if (ld_sub) begin
            twosec_q <= match_q[31:16];
        end else if (i_ls_tick && subsec_q == 16'hFFFF) begin
            if (twosec_q == rttc_pkg::TWOSEC_PER_DAY - 16'h0001) begin
                twosec_q <= 16'h0000;
            end else begin
                twosec_q <= twosec_q + 16'h0001;
            end
        end
    end

    // Day counter with its own load
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            day_q <= '0;
        end else if (ld_day) begin
            day_q <= match_q[rttc_pkg::DAY_WIDTH-1:0];
        end else if (i_ls_tick && subsec_q == 16'hFFFF
                     && twosec_q == rttc_pkg::TWOSEC_PER_DAY - 16'h0001) begin
            day_q <= day_q + 14'h0001;
        end
    end

    // ========================================================================
    // Configuration registers survive system reset; only power-on clears them

    // Mode fields; the load bits are strobes and are not stored
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            mode_q.interval   <= rttc_pkg::INTERVAL_RST;
            mode_q.period_en  <= 1'b0;
            mode_q.alarm_en   <= 1'b0;
            mode_q.ignore_lsb <= 1'b0;
        end else if (wr_mode) begin
            mode_q.interval   <= i_avs_writedata[2:0];
            mode_q.ignore_lsb <= i_avs_writedata[rttc_pkg::MODE_IGN_BIT];
            mode_q.period_en  <= i_avs_writedata[rttc_pkg::MODE_PEN_BIT];
            mode_q.alarm_en   <= i_avs_writedata[rttc_pkg::MODE_AEN_BIT];
        end
    end

    // Match and staging value, written lane by lane
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            match_q <= rttc_pkg::MATCH_RST;
        end else if (wr_match) begin
            for (int b = 0; b < 4; b++) begin
                if (i_avs_byteenable[b]) begin
                    match_q[b*8 +: 8] <= i_avs_writedata[b*8 +: 8];
                end
            end
        end
    end

    // Interrupt mask, same layout as the status register
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            irq_mask_q <= 2'h0;
        end else if (wr_mask) begin
            irq_mask_q <= i_avs_writedata[1:0];
        end
    end

    // ========================================================================
    // Activation flags and sticky status: set wins over clear

    // Alarm entry detector, so a held match fires once
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            alarm_hit_q <= 1'b0;
        end else begin
            alarm_hit_q <= alarm_match;
        end
    end

    // Alarm activation flag
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            alarm_flag_q <= 1'b0;
        end else if (alarm_evt) begin
            alarm_flag_q <= 1'b1;
        end else if (clr_alarm) begin
            alarm_flag_q <= 1'b0;
        end
    end

    // Periodic activation flag
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            period_flag_q <= 1'b0;
        end else if (period_evt) begin
            period_flag_q <= 1'b1;
        end else if (clr_period) begin
            period_flag_q <= 1'b0;
        end
    end

    // Sticky interrupt status, write one to clear
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            irq_stat_q <= 2'h0;
        end else begin
            irq_stat_q[rttc_pkg::IRQ_PERIOD_BIT] <= period_evt
                | (irq_stat_q[rttc_pkg::IRQ_PERIOD_BIT]
                   & ~(wr_stat & i_avs_writedata[rttc_pkg::IRQ_PERIOD_BIT]));
            irq_stat_q[rttc_pkg::IRQ_ALARM_BIT] <= alarm_evt
                | (irq_stat_q[rttc_pkg::IRQ_ALARM_BIT]
                   & ~(wr_stat & i_avs_writedata[rttc_pkg::IRQ_ALARM_BIT]));
        end
    end

    // Interrupt output registered
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ========================================================================
    // Bus answer: one wait cycle, data registered with the acknowledge
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_por) begin
            ack_q          <= 1'b0;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            ack_q <= acc;
            if (acc && i_avs_read) begin
                if (i_avs_address == rttc_pkg::OFS_FLAG) begin
                    o_avs_readdata <= {24'h000000, alarm_flag_q, period_flag_q,
                                       ~mode_q.alarm_en, ~mode_q.period_en,
                                       4'h0};
                end else if (i_avs_address == rttc_pkg::OFS_MODE) begin
                    // Load bits complete at once and read back 0
                    o_avs_readdata <= {24'h000000, 2'h0, mode_q.alarm_en,
                                       mode_q.period_en, mode_q.ignore_lsb,
                                       mode_q.interval};
                end else if (i_avs_address == rttc_pkg::OFS_MATCH) begin
                    o_avs_readdata <= match_q;
                end else if (i_avs_address == rttc_pkg::OFS_SUBSEC) begin
                    o_avs_readdata <= {16'h0000, subsec_q};
                end else if (i_avs_address == rttc_pkg::OFS_TWOSEC) begin
                    o_avs_readdata <= {16'h0000, twosec_q};
                end else if (i_avs_address == rttc_pkg::OFS_DAY) begin
                    o_avs_readdata <= {18'h00000, day_q};
                end else if (i_avs_address == rttc_pkg::OFS_IRQ_STAT) begin
                    o_avs_readdata <= {30'h00000000, irq_stat_q};
                end else if (i_avs_address == rttc_pkg::OFS_IRQ_MASK) begin
                    o_avs_readdata <= {30'h00000000, irq_mask_q};
                end else begin
                    o_avs_readdata <= 32'h0000_0000;
                end
            end
        end
    end

    // Waitrequest high until the acknowledge cycle
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_por) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= ~acc;
        end
    end

endmodule : rttc_top

// *** rttc_top_assertions.sv ***
// Checker for bus handshake, register readback and interrupt masking.
// Assumes writes use all four byte enables; bound to every rttc_top.
`timescale 1ns/100ps
module rttc_top_assertions (
    input wire logic        i_clk,             // System clock
    input wire logic        i_sys_rst,         // System reset
    input wire logic        i_por,             // Power-on reset
    input wire logic        i_ls_tick,         // Low-speed tick
    input wire logic [4:0]  i_avs_address,     // Byte address
    input wire logic        i_avs_read,        // Read request
    input wire logic        i_avs_write,       // Write request
    input wire logic [31:0] i_avs_writedata,   // Write data
    input wire logic [3:0]  i_avs_byteenable,  // Byte enables
    input wire logic [31:0] o_avs_readdata,    // Read data
    input wire logic        o_avs_waitrequest, // Wait request
    input wire logic        o_irq              // Interrupt
);
    // ========================================================================
    // Shadow copies, cleared only by power-on reset
    logic        tkn_w;
    logic [5:0]  mode_q;
    logic [31:0] match_q;
    logic [1:0]  mask_q;
    assign tkn_w = i_avs_write && !o_avs_waitrequest && (i_avs_byteenable == 4'hF);
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            mode_q <= 6'h02;
            match_q <= 32'h0;
            mask_q <= 2'h0;
        end else if (tkn_w) begin
            if (i_avs_address == rttc_pkg::OFS_MODE) mode_q <= i_avs_writedata[5:0];
            if (i_avs_address == rttc_pkg::OFS_MATCH) match_q <= i_avs_writedata;
            if (i_avs_address == rttc_pkg::OFS_IRQ_MASK) mask_q <= i_avs_writedata[1:0];
        end
    end

    // ========================================================================
    // Properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst || i_por);
    sequence s_ans(logic [4:0] ofs);
        !o_avs_waitrequest && $past(i_avs_read) && $past(i_avs_address) == ofs;
    endsequence
    chk_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("wait low too long");
    chk_req_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("request not answered");
    chk_ack_cause: assert property ($fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write))
        else $error("answer without request");
    chk_rst_wait: assert property (disable iff (1'b0) (i_sys_rst || i_por)
        |=> o_avs_waitrequest && o_avs_readdata == 32'h0) else $error("reset bus state");
    chk_flag_read: assert property (s_ans(rttc_pkg::OFS_FLAG) |-> o_avs_readdata[31:8] == 24'h0
        && o_avs_readdata[5:4] == ~mode_q[5:4] && o_avs_readdata[3:0] == 4'h0)
        else $error("flag readback");
    chk_mode_read: assert property (s_ans(rttc_pkg::OFS_MODE)
        |-> o_avs_readdata == {26'h0, mode_q}) else $error("mode readback");
    chk_match_read: assert property (s_ans(rttc_pkg::OFS_MATCH)
        |-> o_avs_readdata == match_q) else $error("match readback");
    chk_day_upper: assert property (s_ans(rttc_pkg::OFS_DAY)
        |-> o_avs_readdata[31:14] == 18'h0) else $error("day upper bits");
    chk_irq_masked: assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !o_irq)
        else $error("masked interrupt seen");
endmodule : rttc_top_assertions

bind rttc_top rttc_top_assertions u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_por(i_por),
    .i_ls_tick(i_ls_tick), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq));

// *** tb.sv ***
// Self-checking bench: counters, loads, alarm, periodic mode, interrupt.
// Assumes the checker is bound separately; the bench drives the ticks.
`timescale 1ns/100ps
module tb;
    logic        i_clk, i_sys_rst, i_por, i_ls_tick, i_avs_read, i_avs_write;
    logic [4:0]  i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata, rdv;
    logic        o_avs_waitrequest, o_irq;
    int          errors, comparisons;
    rttc_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_por(i_por), .i_ls_tick(i_ls_tick),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hF),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq));
    // Clock and watchdog
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    initial begin
        repeat (100000) @(posedge i_clk);
        errors++;
        complete_run;
    end
    // ========================================================================
    // Shared tasks
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s exp %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= w;
        i_avs_read <= !w;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        rdv = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask : bus
    task automatic rc(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), rdv, e);
    endtask : rc
    task automatic ticks(input int n);
        @(posedge i_clk);
        i_ls_tick <= 1'b1;
        repeat (n) @(posedge i_clk);
        i_ls_tick <= 1'b0;
    endtask : ticks
    task automatic irqc(input logic e);
        repeat (3) @(posedge i_clk);
        check("irq", {31'h0, o_irq}, {31'h0, e});
    endtask : irqc
    // ========================================================================
    // Scenarios
    task automatic t_reset;
        rc(rttc_pkg::OFS_FLAG, 32'h30);
        rc(rttc_pkg::OFS_MODE, 32'h02);
        rc(rttc_pkg::OFS_MATCH, 32'h0);
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, rttc_pkg::OFS_MODE, 32'(c));
            rc(rttc_pkg::OFS_MODE, 32'(c));
        end
    endtask : t_reset
    task automatic t_load;
        bus(1'b1, rttc_pkg::OFS_MATCH, 32'hFFFF_C123);
        bus(1'b1, rttc_pkg::OFS_MODE, 32'h82);
        rc(rttc_pkg::OFS_DAY, 32'h123);
        bus(1'b1, rttc_pkg::OFS_MATCH, 32'h0005_0010);
        bus(1'b1, rttc_pkg::OFS_MODE, 32'h42);
        rc(rttc_pkg::OFS_TWOSEC, 32'h5);
        bus(1'b1, rttc_pkg::OFS_SUBSEC, 32'hFFFF);
        ticks(3);
        rc(rttc_pkg::OFS_SUBSEC, 32'h13);
        bus(1'b1, rttc_pkg::OFS_MATCH, 32'h0007_FFFF);
        bus(1'b1, rttc_pkg::OFS_MODE, 32'h42);
        ticks(1);
        rc(rttc_pkg::OFS_TWOSEC, 32'h8);
        bus(1'b1, rttc_pkg::OFS_MATCH, 32'hA8BF_FFFF);
        bus(1'b1, rttc_pkg::OFS_MODE, 32'h42);
        ticks(1);
        rc(rttc_pkg::OFS_TWOSEC, 32'h0);
        rc(rttc_pkg::OFS_DAY, 32'h124);
    endtask : t_load
    task automatic t_alarm;
        bus(1'b1, rttc_pkg::OFS_IRQ_MASK, 32'h3);
        bus(1'b1, rttc_pkg::OFS_MATCH, 32'h0);
        bus(1'b1, rttc_pkg::OFS_MODE, 32'h42);
        bus(1'b1, rttc_pkg::OFS_MATCH, 32'h4);
        bus(1'b1, rttc_pkg::OFS_MODE, 32'h22);
        ticks(3);
        rc(rttc_pkg::OFS_FLAG, 32'h10);
        ticks(1);
        rc(rttc_pkg::OFS_FLAG, 32'h90);
        irqc(1'b1);
        rc(rttc_pkg::OFS_IRQ_STAT, 32'h2);
        bus(1'b1, rttc_pkg::OFS_MODE, 32'h02);
        bus(1'b1, rttc_pkg::OFS_FLAG, 32'h20);
        rc(rttc_pkg::OFS_FLAG, 32'hB0);
        bus(1'b1, rttc_pkg::OFS_MODE, 32'h22);
        bus(1'b1, rttc_pkg::OFS_FLAG, 32'h20);
        rc(rttc_pkg::OFS_FLAG, 32'h10);
        bus(1'b1, rttc_pkg::OFS_MATCH, 32'h0);
        bus(1'b1, rttc_pkg::OFS_MODE, 32'h42);
        bus(1'b1, rttc_pkg::OFS_IRQ_STAT, 32'h3);
        bus(1'b1, rttc_pkg::OFS_MATCH, 32'h5);
        bus(1'b1, rttc_pkg::OFS_MODE, 32'h2A);
        ticks(4);
        rc(rttc_pkg::OFS_FLAG, 32'h90);
        bus(1'b1, rttc_pkg::OFS_IRQ_MASK, 32'h0);
        irqc(1'b0);
        bus(1'b1, rttc_pkg::OFS_IRQ_MASK, 32'h3);
        irqc(1'b1);
        bus(1'b1, rttc_pkg::OFS_IRQ_STAT, 32'h3);
        irqc(1'b0);
        bus(1'b1, rttc_pkg::OFS_FLAG, 32'h20);
    endtask : t_alarm
    task automatic t_period;
        for (int c = 0; c < 2; c++) begin
            bus(1'b1, rttc_pkg::OFS_MATCH, 32'h0);
            bus(1'b1, rttc_pkg::OFS_MODE, 32'h50 | 32'(c));
            ticks((4096 << c) - 6);
            rc(rttc_pkg::OFS_FLAG, 32'h20);
            ticks(12);
            rc(rttc_pkg::OFS_FLAG, 32'h60);
            irqc(1'b1);
            bus(1'b1, rttc_pkg::OFS_FLAG, 32'h10);
            rc(rttc_pkg::OFS_FLAG, 32'h20);
            bus(1'b1, rttc_pkg::OFS_IRQ_STAT, 32'h1);
        end
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rc(rttc_pkg::OFS_MODE, 32'h11);
        rc(rttc_pkg::OFS_SUBSEC, 32'h2006);
    endtask : t_period
    task automatic t_relative;
        logic [31:0] alarm_target_value;
        logic [31:0] alarm_delay_seconds;
        alarm_delay_seconds = 32'h1;
        bus(1'b1, rttc_pkg::OFS_MODE, 32'h02);
        // Ticks pause while a new low-speed source settles
        repeat (rttc_pkg::SWITCH_WAIT_US * (rttc_pkg::SYS_CLK_HZ / 1_000_000)) begin
            @(posedge i_clk);
        end
        rc(rttc_pkg::OFS_SUBSEC, 32'h2006);
        // Software forms the target from the current count
        bus(1'b0, rttc_pkg::OFS_SUBSEC, 32'h0);
        alarm_target_value[15:0] = rdv[15:0];
        bus(1'b0, rttc_pkg::OFS_TWOSEC, 32'h0);
        alarm_target_value[31:16] = rdv[15:0];
        alarm_target_value = alarm_target_value
                             + alarm_delay_seconds * 32'(rttc_pkg::LS_CLK_HZ);
        bus(1'b1, rttc_pkg::OFS_MATCH, alarm_target_value);
        bus(1'b1, rttc_pkg::OFS_MODE, 32'h22);
        ticks(rttc_pkg::LS_CLK_HZ - 1);
        rc(rttc_pkg::OFS_FLAG, 32'h10);
        ticks(1);
        rc(rttc_pkg::OFS_FLAG, 32'h90);
        irqc(1'b1);
        bus(1'b1, rttc_pkg::OFS_FLAG, 32'h20);
        bus(1'b1, rttc_pkg::OFS_IRQ_STAT, 32'h3);
    endtask : t_relative
    task automatic complete_run;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    // Reset and main sequence
    initial begin
        {i_sys_rst, i_por, i_ls_tick, i_avs_read, i_avs_write} = 5'h18;
        i_avs_address = 5'h0;
        i_avs_writedata = 32'h0;
        errors = 0;
        comparisons = 0;
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        i_por <= 1'b0;
        t_reset;
        t_load;
        t_alarm;
        t_period;
        t_relative;
        complete_run;
    end
endmodule : tb
